// ---- logic/xcvr_pkg.sv ----
// constants for the registered bus transceiver and its register slave
package xcvr_pkg;
   localparam int unsigned LANES = 16;
   localparam int unsigned HALF = 8;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned EVT_W = 4;
   // register byte offsets
   localparam logic [7:0] OFF_STORED_A = 8'h00;
   localparam logic [7:0] OFF_STORED_B = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_CAPTURE = 8'h0C;
   localparam logic [7:0] OFF_EVENT = 8'h10;
   // status field positions, two bits each (one per half)
   localparam int unsigned ST_B_DRV_POS = 0;
   localparam int unsigned ST_A_DRV_POS = 2;
   localparam int unsigned ST_A_SEL_POS = 4;
   localparam int unsigned ST_B_SEL_POS = 6;
   // capture and event fields: A halves in [1:0], B halves in [3:2]
   localparam int unsigned EV_A_POS = 0;
   localparam int unsigned EV_B_POS = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // reset values
   localparam logic PREV_CLK_RST = 1'b1;
   localparam logic [EVT_W-1:0] EVENT_RST = 4'h0;
   localparam logic OE_N_RST = 1'b1;
endpackage

// ---- logic/capture_slice.sv ----
// one storage register with its capture-edge detector
`timescale 1ns/1ps
module capture_slice #(
   parameter int unsigned WIDTH = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic capture_level,
   input wire logic sw_capture,
   input wire logic [WIDTH-1:0] bus_level,
   output logic [WIDTH-1:0] stored,
   output logic captured
);
   logic prev_ff;
   logic captured_ff;
   logic [WIDTH-1:0] stored_ff;
   wire logic take = (capture_level & ~prev_ff) | sw_capture;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_ff <= xcvr_pkg::PREV_CLK_RST;
         captured_ff <= 1'b0;
      end else begin
         prev_ff <= capture_level;
         captured_ff <= take;
      end
   end

   // storage has no reset and ignores selects and enables
   always_ff @(posedge aclk) begin
      if (take) begin
         stored_ff <= bus_level;
      end
   end

   assign stored = stored_ff;
   assign captured = captured_ff;
endmodule

// ---- logic/skid_buffer2.sv ----
// two-entry valid/ready buffer
`timescale 1ns/1ps
module skid_buffer2 #(
   parameter int unsigned WIDTH = 34
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic out_valid_ff;
   logic skid_valid_ff;
   logic [WIDTH-1:0] out_data_ff;
   logic [WIDTH-1:0] skid_data_ff;
   wire logic push = in_valid & ~skid_valid_ff;
   wire logic pop = out_valid_ff & out_ready;
   wire logic out_free = ~out_valid_ff | pop;
   wire logic nxt_out_valid = out_free ? (skid_valid_ff | push) : 1'b1;
   wire logic nxt_skid_valid = out_free ? 1'b0 : (skid_valid_ff | push);
   wire logic [WIDTH-1:0] nxt_out_data =
      !out_free ? out_data_ff : (skid_valid_ff ? skid_data_ff : in_data);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_valid_ff <= 1'b0;
         skid_valid_ff <= 1'b0;
      end else begin
         out_valid_ff <= nxt_out_valid;
         skid_valid_ff <= nxt_skid_valid;
      end
   end

   always_ff @(posedge aclk) begin
      out_data_ff <= nxt_out_data;
      if (push && !out_free) begin
         skid_data_ff <= in_data;
      end
   end

   assign in_ready = ~skid_valid_ff;
   assign out_valid = out_valid_ff;
   assign out_data = out_data_ff;
endmodule

// ---- logic/registered_bus_transceiver.sv ----
// registered 16-bit bus transceiver with an AXI4-Lite register slave
`timescale 1ns/1ps
module registered_bus_transceiver #(
   parameter int unsigned LANES = xcvr_pkg::LANES,
   parameter int unsigned HALF = xcvr_pkg::HALF,
   localparam int unsigned NH = LANES / HALF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [NH-1:0] a_to_b_drive_enable,
   input wire logic [NH-1:0] b_to_a_drive_enable_n,
   input wire logic [NH-1:0] a_to_b_source_select,
   input wire logic [NH-1:0] b_to_a_source_select,
   input wire logic [NH-1:0] a_side_capture_clock,
   input wire logic [NH-1:0] b_side_capture_clock,
   input wire logic [LANES-1:0] a_in,
   output logic [LANES-1:0] a_out,
   output logic [LANES-1:0] a_oe_n,
   input wire logic [LANES-1:0] b_in,
   output logic [LANES-1:0] b_out,
   output logic [LANES-1:0] b_oe_n,
   input wire logic [xcvr_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [xcvr_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [xcvr_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [xcvr_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   localparam int unsigned RW = xcvr_pkg::DATA_W + 2;

   if (NH != 2 || LANES != NH * HALF || LANES > xcvr_pkg::DATA_W) begin
      $error("lane count must split into two halves within 32 bits");
   end

   function automatic logic is_mapped(input logic [xcvr_pkg::ADDR_W-1:0] a);
      is_mapped = (a == xcvr_pkg::OFF_STORED_A) ||
         (a == xcvr_pkg::OFF_STORED_B) || (a == xcvr_pkg::OFF_STATUS) ||
         (a == xcvr_pkg::OFF_CAPTURE) || (a == xcvr_pkg::OFF_EVENT);
   endfunction

   // pin side registers
   logic [LANES-1:0] a_out_ff;
   logic [LANES-1:0] a_oe_n_ff;
   logic [LANES-1:0] b_out_ff;
   logic [LANES-1:0] b_oe_n_ff;
   logic [LANES-1:0] nxt_a_out;
   logic [LANES-1:0] nxt_a_oe_n;
   logic [LANES-1:0] nxt_b_out;
   logic [LANES-1:0] nxt_b_oe_n;
   logic [LANES-1:0] stored_a;
   logic [LANES-1:0] stored_b;
   logic [LANES-1:0] a_level;
   logic [LANES-1:0] b_level;
   logic [NH-1:0] cap_a_evt;
   logic [NH-1:0] cap_b_evt;
   logic [NH-1:0] sw_cap_a;
   logic [NH-1:0] sw_cap_b;

   // bus level seen by capture: own drive when driving, else the pins
   assign a_level = (~a_oe_n_ff & a_out_ff) | (a_oe_n_ff & a_in);
   assign b_level = (~b_oe_n_ff & b_out_ff) | (b_oe_n_ff & b_in);

   for (genvar h = 0; h < NH; h++) begin : g_half
      // each half owns its controls and registers
      capture_slice #(.WIDTH(HALF)) u_cap_a (
         .aclk(aclk),
         .aresetn(aresetn),
         .capture_level(a_side_capture_clock[h]),
         .sw_capture(sw_cap_a[h]),
         .bus_level(a_level[h*HALF +: HALF]),
         .stored(stored_a[h*HALF +: HALF]),
         .captured(cap_a_evt[h])
      );
      capture_slice #(.WIDTH(HALF)) u_cap_b (
         .aclk(aclk),
         .aresetn(aresetn),
         .capture_level(b_side_capture_clock[h]),
         .sw_capture(sw_cap_b[h]),
         .bus_level(b_level[h*HALF +: HALF]),
         .stored(stored_b[h*HALF +: HALF]),
         .captured(cap_b_evt[h])
      );

      // A to B: live A when select low, stored A when high
      assign nxt_b_out[h*HALF +: HALF] = a_to_b_source_select[h] ?
         stored_a[h*HALF +: HALF] : a_in[h*HALF +: HALF];
      // B to A: live B when select low, stored B when high
      assign nxt_a_out[h*HALF +: HALF] = b_to_a_source_select[h] ?
         stored_b[h*HALF +: HALF] : b_in[h*HALF +: HALF];
      // port direction from the enables only
      assign nxt_b_oe_n[h*HALF +: HALF] =
         {HALF{~a_to_b_drive_enable[h]}};
      assign nxt_a_oe_n[h*HALF +: HALF] =
         {HALF{b_to_a_drive_enable_n[h]}};
   end

   // registered outputs: a select change moves all lanes of its half on one edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         a_out_ff <= '0;
         b_out_ff <= '0;
         a_oe_n_ff <= {LANES{xcvr_pkg::OE_N_RST}};
         b_oe_n_ff <= {LANES{xcvr_pkg::OE_N_RST}};
      end else begin
         a_out_ff <= nxt_a_out;
         b_out_ff <= nxt_b_out;
         a_oe_n_ff <= nxt_a_oe_n;
         b_oe_n_ff <= nxt_b_oe_n;
      end
   end

   assign a_out = a_out_ff;
   assign b_out = b_out_ff;
   assign a_oe_n = a_oe_n_ff;
   assign b_oe_n = b_oe_n_ff;

   // write channel
   logic aw_held_ff;
   logic w_held_ff;
   logic bvalid_ff;
   logic awready_ff;
   logic wready_ff;
   logic [1:0] bresp_ff;
   logic [xcvr_pkg::ADDR_W-1:0] awaddr_ff;
   logic [xcvr_pkg::DATA_W-1:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic [xcvr_pkg::EVT_W-1:0] event_ff;
   logic [xcvr_pkg::EVT_W-1:0] cap_cmd;
   logic [xcvr_pkg::EVT_W-1:0] ev_clr;
   logic [xcvr_pkg::EVT_W-1:0] ev_set;
   logic [xcvr_pkg::EVT_W-1:0] nxt_event;

   wire logic aw_take = awvalid & awready_ff;
   wire logic w_take = wvalid & wready_ff;
   wire logic wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
   wire logic nxt_aw_held = (aw_held_ff | aw_take) & ~wr_fire;
   wire logic nxt_w_held = (w_held_ff | w_take) & ~wr_fire;
   wire logic nxt_bvalid = wr_fire | (bvalid_ff & ~bready);
   wire logic nxt_awready = ~nxt_aw_held & ~nxt_bvalid;
   wire logic nxt_wready = ~nxt_w_held & ~nxt_bvalid;
   wire logic [1:0] nxt_bresp = is_mapped(awaddr_ff) ?
      xcvr_pkg::RESP_OKAY : xcvr_pkg::RESP_SLVERR;
   wire logic wr_lane0 = wr_fire & wstrb_ff[0];

   assign cap_cmd = (wr_lane0 && awaddr_ff == xcvr_pkg::OFF_CAPTURE) ?
      wdata_ff[xcvr_pkg::EVT_W-1:0] : '0;
   assign ev_clr = (wr_lane0 && awaddr_ff == xcvr_pkg::OFF_EVENT) ?
      wdata_ff[xcvr_pkg::EVT_W-1:0] : '0;
   assign sw_cap_a = cap_cmd[xcvr_pkg::EV_A_POS +: NH];
   assign sw_cap_b = cap_cmd[xcvr_pkg::EV_B_POS +: NH];
   assign ev_set = {cap_b_evt, cap_a_evt};
   // a capture in the clearing cycle survives
   assign nxt_event = (event_ff & ~ev_clr) | ev_set;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         bresp_ff <= xcvr_pkg::RESP_OKAY;
         event_ff <= xcvr_pkg::EVENT_RST;
      end else begin
         aw_held_ff <= nxt_aw_held;
         w_held_ff <= nxt_w_held;
         bvalid_ff <= nxt_bvalid;
         awready_ff <= nxt_awready;
         wready_ff <= nxt_wready;
         event_ff <= nxt_event;
         if (wr_fire) begin
            bresp_ff <= nxt_bresp;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (aw_take) begin
         awaddr_ff <= awaddr;
      end
      if (w_take) begin
         wdata_ff <= wdata;
         wstrb_ff <= wstrb;
      end
   end

   assign awready = awready_ff;
   assign wready = wready_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;

   // read channel through the two-entry buffer
   logic [7:0] status_word;
   logic [xcvr_pkg::DATA_W-1:0] rd_word;
   logic [1:0] rd_resp;
   logic [RW-1:0] rd_out;
   logic rd_in_ready;

   for (genvar h = 0; h < NH; h++) begin : g_status
      assign status_word[xcvr_pkg::ST_B_DRV_POS + h] = ~b_oe_n_ff[h*HALF];
      assign status_word[xcvr_pkg::ST_A_DRV_POS + h] = ~a_oe_n_ff[h*HALF];
      assign status_word[xcvr_pkg::ST_A_SEL_POS + h] =
         a_to_b_source_select[h];
      assign status_word[xcvr_pkg::ST_B_SEL_POS + h] =
         b_to_a_source_select[h];
   end

   assign rd_word =
      (araddr == xcvr_pkg::OFF_STORED_A) ? xcvr_pkg::DATA_W'(stored_a) :
      (araddr == xcvr_pkg::OFF_STORED_B) ? xcvr_pkg::DATA_W'(stored_b) :
      (araddr == xcvr_pkg::OFF_STATUS) ? xcvr_pkg::DATA_W'(status_word) :
      (araddr == xcvr_pkg::OFF_EVENT) ? xcvr_pkg::DATA_W'(event_ff) :
      '0;
   assign rd_resp = is_mapped(araddr) ?
      xcvr_pkg::RESP_OKAY : xcvr_pkg::RESP_SLVERR;

   skid_buffer2 #(.WIDTH(RW)) u_rd_buf (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_valid(arvalid),
      .in_ready(rd_in_ready),
      .in_data({rd_resp, rd_word}),
      .out_valid(rvalid),
      .out_ready(rready),
      .out_data(rd_out)
   );

   assign arready = rd_in_ready;
   assign rresp = rd_out[RW-1 -: 2];
   assign rdata = rd_out[xcvr_pkg::DATA_W-1:0];

   // with selects high, simultaneous edges store the old register; the
   // far side staggers them when loading one bus into both
endmodule

// ---- test/xcvr_checker.sv ----
// assertions on the transceiver top-level ports
`timescale 1ns/1ps
module xcvr_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] a_to_b_drive_enable,
   input wire logic [1:0] b_to_a_drive_enable_n,
   input wire logic [1:0] a_to_b_source_select,
   input wire logic [1:0] b_to_a_source_select,
   input wire logic [1:0] a_side_capture_clock,
   input wire logic [15:0] a_in,
   input wire logic [15:0] b_in,
   input wire logic [15:0] a_out,
   input wire logic [15:0] a_oe_n,
   input wire logic [15:0] b_out,
   input wire logic [15:0] b_oe_n,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready
);
   logic prev_ff;
   wire rise = a_side_capture_clock[0] & ~prev_ff;
   wire st_ab = a_to_b_drive_enable[0] & a_to_b_source_select[0];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_ff <= 1'h1;
      end else begin
         prev_ff <= a_side_capture_clock[0];
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_B_OE: assert property (1 |=> b_oe_n == ~{
      {8{$past(a_to_b_drive_enable[1])}}, {8{$past(a_to_b_drive_enable[0])}}})
      else $error("b drive enable wrong");
   AST_A_OFF: assert property (
      $rose(b_to_a_drive_enable_n[0]) |=> a_oe_n[7:0] == 8'hFF)
      else $error("a port still driving");
   AST_LIVE_AB: assert property (
      a_to_b_drive_enable[0] && !a_to_b_source_select[0]
      |=> b_out[7:0] == $past(a_in[7:0])) else $error("live a to b wrong");
   AST_LIVE_BA: assert property (
      !b_to_a_drive_enable_n[1] && !b_to_a_source_select[1]
      |=> a_out[15:8] == $past(b_in[15:8])) else $error("live b to a wrong");
   AST_STORED_HOLD: assert property (
      st_ab && $past(st_ab) && !$past(rise) && $past(awready)
      |=> $stable(b_out[7:0])) else $error("stored output moved");
   AST_CAPTURE_A: assert property (
      rise && !awvalid ##1 st_ab |=> b_out[7:0] == $past(a_in[7:0], 2))
      else $error("capture value wrong");
   AST_WRITE_RESP: assert property (
      awvalid && awready && wvalid && wready |=> !awready ##1 bvalid)
      else $error("write response late");
   AST_NO_SECOND_WRITE: assert property (
      bvalid |-> !awready && !wready) else $error("write taken early");
   cover property (rise ##1 st_ab);
   cover property (!a_oe_n[0] && !b_oe_n[0]);
   cover property (bvalid && bready && bresp == xcvr_pkg::RESP_SLVERR);
endmodule
bind registered_bus_transceiver xcvr_checker u_chk (.*);

// ---- test/bus_partner.sv ----
// far-side bus logic resolving the A and B pin levels
`timescale 1ns/1ps
module bus_partner (
   input wire logic [15:0] a_out,
   input wire logic [15:0] a_oe_n,
   input wire logic [15:0] b_out,
   input wire logic [15:0] b_oe_n,
   input wire logic [15:0] a_drv,
   input wire logic [15:0] b_drv,
   output logic [15:0] a_in,
   output logic [15:0] b_in
);
   // device lanes win where enabled
   assign a_in = (~a_oe_n & a_out) | (a_oe_n & a_drv);
   assign b_in = (~b_oe_n & b_out) | (b_oe_n & b_drv);
endmodule

// ---- test/tb_top.sv ----
// self-checking bench for the registered bus transceiver
`timescale 1ns/1ps
module tb_top;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [1:0] a_to_b_drive_enable = 2'h0;
   logic [1:0] b_to_a_drive_enable_n = 2'h3;
   logic [1:0] a_to_b_source_select = 2'h0;
   logic [1:0] b_to_a_source_select = 2'h0;
   logic [1:0] a_side_capture_clock = 2'h0;
   logic [1:0] b_side_capture_clock = 2'h0;
   logic [15:0] a_in, a_out, a_oe_n, b_in, b_out, b_oe_n;
   logic [15:0] a_drv = 16'h0000;
   logic [15:0] b_drv = 16'h0000;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'h0;
   logic wvalid = 1'h0;
   logic bready = 1'h0;
   logic arvalid = 1'h0;
   logic rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int n_mismatch = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #2.5 aclk = ~aclk;
   registered_bus_transceiver dut (.*);
   bus_partner far_side (.a_out(a_out), .a_oe_n(a_oe_n),
      .b_out(b_out), .b_oe_n(b_oe_n), .a_drv(a_drv), .b_drv(b_drv),
      .a_in(a_in), .b_in(b_in));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                     input logic [1:0] er);
      @(posedge aclk);
      awaddr <= ad;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      bready <= 1'h0;
      chk(bresp, er);
   endtask
   task automatic rd(input logic [7:0] ad, input logic [31:0] ed,
                     input logic [1:0] er);
      @(posedge aclk);
      araddr <= ad;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      rready <= 1'h0;
      chk(rdata, ed);
      chk(rresp, er);
   endtask
   // controls and far-side data change together, then outputs settle
   task automatic mode(input logic [1:0] e, en, s, t,
                       input logic [15:0] ad, bd);
      @(posedge aclk);
      a_to_b_drive_enable <= e;
      b_to_a_drive_enable_n <= en;
      a_to_b_source_select <= s;
      b_to_a_source_select <= t;
      a_drv <= ad;
      b_drv <= bd;
      repeat (3) @(posedge aclk);
      #1;
   endtask
   task automatic pulse(input logic [1:0] ca, cb);
      @(posedge aclk);
      a_side_capture_clock <= ca;
      b_side_capture_clock <= cb;
      repeat (2) @(posedge aclk);
      a_side_capture_clock <= 2'h0;
      b_side_capture_clock <= 2'h0;
      repeat (2) @(posedge aclk);
   endtask
   task automatic t_live;
      mode(2'h1, 2'h1, 2'h0, 2'h0, 16'hA5C3, 16'h0F96);
      chk(b_oe_n, 16'hFF00);
      chk(a_oe_n, 16'h00FF);
      chk(b_out[7:0], 8'hC3);
      chk(a_out[15:8], 8'h0F);
   endtask
   task automatic t_store;
      mode(2'h0, 2'h3, 2'h0, 2'h0, 16'h1234, 16'h5678);
      pulse(2'h3, 2'h3);
      rd(xcvr_pkg::OFF_STORED_A, 32'h1234, xcvr_pkg::RESP_OKAY);
      rd(xcvr_pkg::OFF_STORED_B, 32'h5678, xcvr_pkg::RESP_OKAY);
      mode(2'h3, 2'h3, 2'h3, 2'h0, 16'hFFFF, 16'h0000);
      chk(b_out, 16'h1234);
      mode(2'h0, 2'h0, 2'h0, 2'h3, 16'hFFFF, 16'h0000);
      chk(a_out, 16'h5678);
      chk(b_oe_n, 16'hFFFF);
      mode(2'h3, 2'h0, 2'h3, 2'h3, 16'h0000, 16'hFFFF);
      chk({a_out, b_out}, 32'h56781234);
   endtask
   task automatic t_both;
      mode(2'h3, 2'h3, 2'h0, 2'h0, 16'h9E01, 16'h0000);
      pulse(2'h3, 2'h3);
      rd(xcvr_pkg::OFF_STORED_B, 32'h9E01, xcvr_pkg::RESP_OKAY);
      mode(2'h3, 2'h3, 2'h3, 2'h0, 16'h4B7D, 16'h0000);
      pulse(2'h3, 2'h0);
      pulse(2'h0, 2'h3);
      rd(xcvr_pkg::OFF_STORED_B, 32'h4B7D, xcvr_pkg::RESP_OKAY);
   endtask
   task automatic t_regs;
      mode(2'h3, 2'h3, 2'h3, 2'h0, 16'h00AA, 16'h0000);
      rd(8'h14, 32'h0, xcvr_pkg::RESP_SLVERR);
      wr(8'h24, 32'hFFFF, xcvr_pkg::RESP_SLVERR);
      wr(xcvr_pkg::OFF_STATUS, 32'h0, xcvr_pkg::RESP_OKAY);
      rd(xcvr_pkg::OFF_STATUS, 32'h33, xcvr_pkg::RESP_OKAY);
      rd(xcvr_pkg::OFF_EVENT, 32'hF, xcvr_pkg::RESP_OKAY);
      wr(xcvr_pkg::OFF_EVENT, 32'hF, xcvr_pkg::RESP_OKAY);
      rd(xcvr_pkg::OFF_EVENT, 32'h0, xcvr_pkg::RESP_OKAY);
      wr(xcvr_pkg::OFF_CAPTURE, 32'h1, xcvr_pkg::RESP_OKAY);
      rd(xcvr_pkg::OFF_STORED_A, 32'h4BAA, xcvr_pkg::RESP_OKAY);
      rd(xcvr_pkg::OFF_EVENT, 32'h1, xcvr_pkg::RESP_OKAY);
      wr(xcvr_pkg::OFF_CAPTURE, 32'hC, xcvr_pkg::RESP_OKAY);
      rd(xcvr_pkg::OFF_STORED_B, 32'h4BAA, xcvr_pkg::RESP_OKAY);
      rd(xcvr_pkg::OFF_EVENT, 32'hD, xcvr_pkg::RESP_OKAY);
   endtask
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (3) @(posedge aclk);
      #1;
      chk({a_oe_n, b_oe_n}, 32'hFFFFFFFF);
      t_live();
      t_store();
      t_both();
      t_regs();
      end_of_test();
   end
endmodule
